// *** src/hbr_pkg.sv ***
`default_nettype none
package hbr_pkg;
  // -------------------------------------------------------------------
  // Clock and timing
  // -------------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned DEB_TIME_MS   = 20;
  localparam int unsigned DEB_CYCLES    = DEB_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned HOLD_TIME_NS  = 1000;
  localparam int unsigned HOLD_CYCLES   = HOLD_TIME_NS * CLK_MHZ / 1000;
  localparam int unsigned ARB_TIME_NS   = 1000;
  localparam int unsigned ARB_CYCLES    = ARB_TIME_NS * CLK_MHZ / 1000;
  localparam int unsigned DEF_KBPS      = 78;
  // Bit period at the default rate, rounded down
  localparam int unsigned DEF_DIV       = CLK_MHZ * 1000 / DEF_KBPS;
  localparam int unsigned CNT_W         = 23;
  localparam int unsigned HOLD_W        = 9;

  // -------------------------------------------------------------------
  // Configuration memory
  // -------------------------------------------------------------------
  localparam int unsigned CFG_BYTES     = 2048;
  localparam int unsigned CMD_BITS      = 24;
  localparam int unsigned XFER_BITS     = CMD_BITS + CFG_BYTES * 8;
  localparam int unsigned XCNT_W        = 15;
  localparam logic [23:0] SPI_READ_CMD  = 24'h030000;
  // Memory clock half period; the four-edge input lag needs at least 3
  localparam int unsigned SCK_HALF      = 3;

  // -------------------------------------------------------------------
  // Inter-half port
  // -------------------------------------------------------------------
  localparam int unsigned LINK_W        = 12;
  localparam int unsigned ARB_A_BIT     = 6;
  localparam int unsigned ARB_B_BIT     = 7;
  localparam int unsigned HS_BIT        = 10;
  localparam int unsigned SPARE_BIT     = 11;
  localparam logic [11:0] OD_MASK       = 12'h4C0;
  localparam logic [11:0] SPARE_MASK    = 12'h800;

  // Boot sequence, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_HOLD   = 3'h0,
    ST_SETTLE = 3'h1,
    ST_ARB    = 3'h3,
    ST_LOAD   = 3'h2,
    ST_RUN    = 3'h6,
    ST_UNCONF = 3'h7
  } hbr_state_e;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_XFER = 2'h1,
    RD_FIN  = 2'h3
  } hbr_rd_state_e;
endpackage : hbr_pkg
`default_nettype wire

// *** src/hbr_cfg_if.sv ***
`default_nettype none
interface hbr_cfg_if;
  logic        start;
  logic        done;
  logic        csum_ok;
  logic [15:0] bit_div;

  modport ctrl (output start, input done, input csum_ok, input bit_div);
  modport rdr  (input start, output done, output csum_ok, output bit_div);
endinterface : hbr_cfg_if
`default_nettype wire

// *** src/hbr_cfg_reader.sv ***
`default_nettype none
module hbr_cfg_reader
  import hbr_pkg::*;
(
  // Clock and reset
  input  wire logic   core_clk_in,
  input  wire logic   reset_n_in,
  // Control side
  hbr_cfg_if.rdr      cfg,
  // Serial memory pins, MISO already synchronised
  input  wire logic   miso_in,
  output logic        sck_out,
  output logic        cs_n_out,
  output logic        mosi_out
);
  hbr_rd_state_e      st_q, st_d;
  logic [XCNT_W-1:0]  bit_q, bit_d;
  logic [2:0]         ph_q, ph_d;
  logic               sck_q, sck_d, cs_n_q, cs_n_d, mosi_q, mosi_d;
  logic [7:0]         sh_q, sh_d, sum_q, sum_d;
  logic [15:0]        div_q, div_d;
  logic               done_q, done_d;
  logic [XCNT_W-1:0]  rx_idx;

  // -------------------------------------------------------------------
  // Sequential read of the first 2 KB, checksum on the fly
  // -------------------------------------------------------------------
  assign rx_idx = bit_q - XCNT_W'(CMD_BITS);

  always_comb begin
    st_d = st_q; bit_d = bit_q; ph_d = ph_q; sck_d = sck_q;
    cs_n_d = cs_n_q; mosi_d = mosi_q; sh_d = sh_q; sum_d = sum_q;
    div_d = div_q; done_d = 1'b0;
    unique case (st_q)
      RD_IDLE: begin
        if (cfg.start) begin
          st_d = RD_XFER; cs_n_d = 1'b0; bit_d = '0; ph_d = '0;
          sum_d = '0; div_d = '0;
          mosi_d = SPI_READ_CMD[23];
        end
      end
      RD_XFER: begin
        ph_d = ph_q + 3'h1;
        if (ph_q == 3'(SCK_HALF - 1)) begin
          ph_d = '0;
          sck_d = ~sck_q;
          if (sck_q && bit_q >= XCNT_W'(CMD_BITS)) begin
            // Take the bit just before the fall: the synchronised copy lags
            // four edges, so at the rise it would still show the previous bit
            sh_d = {sh_q[6:0], miso_in};
            if (rx_idx[2:0] == 3'h7) begin
              sum_d = sum_q + {sh_q[6:0], miso_in};
              if (rx_idx[XCNT_W-1:3] == '0) div_d[15:8] = {sh_q[6:0], miso_in};
              if (rx_idx[XCNT_W-1:3] == 12'h1) div_d[7:0] = {sh_q[6:0], miso_in};
            end
          end
          if (sck_q) begin
            // Falling edge: next bit; stop after 2 KB, never beyond
            bit_d = bit_q + 1'b1;
            if (bit_q == XCNT_W'(XFER_BITS - 1)) begin
              st_d = RD_FIN; cs_n_d = 1'b1;
            end else if (bit_q < XCNT_W'(CMD_BITS - 1)) begin
              mosi_d = SPI_READ_CMD[5'(CMD_BITS - 2) - bit_q[4:0]];
            end else begin
              mosi_d = 1'b0;
            end
          end
        end
      end
      RD_FIN: begin
        done_d = 1'b1;
        st_d = RD_IDLE;
      end
      default: st_d = RD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= RD_IDLE; bit_q <= '0; ph_q <= '0; sck_q <= 1'b0;
      cs_n_q <= 1'b1; mosi_q <= 1'b0; sh_q <= '0; sum_q <= '0;
      div_q <= '0; done_q <= 1'b0;
    end else begin
      st_q <= st_d; bit_q <= bit_d; ph_q <= ph_d; sck_q <= sck_d;
      cs_n_q <= cs_n_d; mosi_q <= mosi_d; sh_q <= sh_d; sum_q <= sum_d;
      div_q <= div_d; done_q <= done_d;
    end
  end

  assign sck_out     = sck_q;
  assign cs_n_out    = cs_n_q;
  assign mosi_out    = mosi_q;
  assign cfg.done    = done_q;
  assign cfg.csum_ok = (sum_q == 8'h00);
  assign cfg.bit_div = div_q;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  chk_read_bound: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !cs_n_q |-> bit_q < XCNT_W'(XFER_BITS))
    else $error("memory read ran past 2 KB");
  chk_read_ends: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (st_q == RD_FIN) |-> cs_n_q ##1 done_q)
    else $error("read finish not reported");
endmodule : hbr_cfg_reader
`default_nettype wire

// *** src/hbr_reset_boot.sv ***
`default_nettype none
// Operation
// - Unconfigured port runs 78 kbps single-ended defaults
// - Defaults allow image download at 78 kbps
// - Twelve inter-half lines, same-numbered wiring
// - Power-up arbitration test needs lines idling high
// - Handshake line open-drain, idles high
// - Spare highest line never driven
// - Configuration memory reached over serial link
// - Only first 2 KB of memory read
// - Router configuration read from serial memory
// - Reset line input by default, pulled up
// - Drive reset low on internal reset sources
// - External low on reset line requests reset; code ignores it while in ST_ARB and ST_LOAD
// - Checksum failure leaves device unconfigured
// - Reset input tolerates 20 ms contact bounce
// - Network port single-ended with four lines
module hbr_reset_boot
  import hbr_pkg::*;
#(
  parameter int unsigned DEB_LEN = DEB_CYCLES
) (
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  // Open-drain reset line and internal reset sources
  input  wire logic              rst_line_n_in,
  output logic                   rst_line_n_out,
  output logic                   rst_line_oe_out,
  input  wire logic              low_voltage_detector_in,
  input  wire logic              sw_reset_in,
  input  wire logic              watchdog_expired_in,
  input  wire logic              trap_in,
  // Inter-half port
  input  wire logic [LINK_W-1:0] link_lines_in,
  output logic [LINK_W-1:0]      link_lines_out,
  output logic [LINK_W-1:0]      link_lines_oe_out,
  input  wire logic [LINK_W-1:0] link_tx_in,
  input  wire logic [LINK_W-1:0] link_tx_en_in,
  output logic [LINK_W-1:0]      link_rx_out,
  // Serial configuration memory
  output logic                   mem_sck_out,
  output logic                   mem_cs_n_out,
  output logic                   mem_mosi_out,
  input  wire logic              mem_miso_in,
  // Network port lines
  input  wire logic              net_rxd_in,
  input  wire logic              net_cd_in,
  output logic                   net_txd_out,
  output logic                   net_tx_en_out,
  // Core side of the network port and status
  input  wire logic              mac_txd_in,
  input  wire logic              mac_tx_en_in,
  output logic                   mac_rxd_out,
  output logic                   mac_cd_out,
  output logic [15:0]            net_bit_div_out,
  output logic                   net_enable_out,
  output logic                   configured_out,
  output logic                   arb_ok_out
);
  // -------------------------------------------------------------------
  // Input synchronisers: three flops, change taken when 2nd and 3rd agree
  // -------------------------------------------------------------------
  localparam int unsigned NS = 8 + LINK_W;
  logic [NS-1:0] raw, s1_q, s2_q, s3_q, flt_q, flt_d;

  assign raw = {link_lines_in, mem_miso_in, net_cd_in, net_rxd_in, trap_in,
                watchdog_expired_in, sw_reset_in, low_voltage_detector_in,
                rst_line_n_in};

  for (genvar i = 0; i < NS; i++) begin : g_flt
    always_comb begin
      flt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i];
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_q <= '0; s2_q <= '0; s3_q <= '0; flt_q <= '0;
    end else begin
      s1_q <= raw; s2_q <= s1_q; s3_q <= s2_q; flt_q <= flt_d;
    end
  end

  logic                line_hi, src_any, miso_s;
  logic [LINK_W-1:0]   link_s;
  assign line_hi = flt_q[0];
  // Internal reset sources
  assign src_any = |flt_q[4:1];
  assign miso_s  = flt_q[7];
  assign link_s  = flt_q[NS-1:8];

  // -------------------------------------------------------------------
  // Configuration reader
  // -------------------------------------------------------------------
  hbr_cfg_if cfg ();

  hbr_cfg_reader u_rdr (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .cfg         (cfg),
    .miso_in     (miso_s),
    .sck_out     (mem_sck_out),
    .cs_n_out    (mem_cs_n_out),
    .mosi_out    (mem_mosi_out)
  );

  // -------------------------------------------------------------------
  // Boot sequencer
  // -------------------------------------------------------------------
  hbr_state_e          st_q, st_d;
  logic [CNT_W-1:0]    cnt_q, cnt_d;
  logic [HOLD_W-1:0]   hold_q, hold_d;
  logic                oe_q, oe_d, start_q, start_d, cfgd_q, cfgd_d;
  logic [15:0]         div_q, div_d;

  // Line low while we do not drive it is someone else's reset request
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; hold_d = hold_q; start_d = 1'b0;
    cfgd_d = cfgd_q; div_d = div_q;
    oe_d = src_any || (hold_q != '0);
    if (hold_q != '0) hold_d = hold_q - 1'b1;
    if (src_any) begin
      st_d = ST_HOLD;
      hold_d = HOLD_W'(HOLD_CYCLES);
    end else begin
      unique case (st_q)
        ST_HOLD: begin
          cnt_d = '0;
          // Released driver lets the pull-up raise the line
          if (!oe_q && line_hi) st_d = ST_SETTLE;
        end
        ST_SETTLE: begin
          // Any bounce restarts the wait
          if (!line_hi) begin
            cnt_d = '0;
          end else if (cnt_q == CNT_W'(DEB_LEN - 1)) begin
            st_d = ST_ARB;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        ST_ARB: begin
          // Both arbitration lines must idle high
          if (!(link_s[ARB_A_BIT] && link_s[ARB_B_BIT])) begin
            cnt_d = '0;
          end else if (cnt_q == CNT_W'(ARB_CYCLES - 1)) begin
            st_d = ST_LOAD;
            start_d = 1'b1;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        ST_LOAD: begin
          if (cfg.done) begin
            // Bad checksum or blank rate leaves us unconfigured
            if (cfg.csum_ok && cfg.bit_div != 16'h0000) begin
              st_d = ST_RUN; cfgd_d = 1'b1; div_d = cfg.bit_div;
            end else begin
              st_d = ST_UNCONF; cfgd_d = 1'b0; div_d = 16'(DEF_DIV);
            end
          end
        end
        ST_RUN, ST_UNCONF: begin
          if (!line_hi) st_d = ST_HOLD;
        end
        default: st_d = ST_HOLD;
      endcase
    end
    if (st_d == ST_HOLD) cfgd_d = 1'b0;
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= ST_HOLD; cnt_q <= '0; hold_q <= '0; oe_q <= 1'b0;
      start_q <= 1'b0; cfgd_q <= 1'b0; div_q <= 16'(DEF_DIV);
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; hold_q <= hold_d; oe_q <= oe_d;
      start_q <= start_d; cfgd_q <= cfgd_d; div_q <= div_d;
    end
  end

  assign cfg.start = start_q;

  // -------------------------------------------------------------------
  // Network port and inter-half port registers
  // -------------------------------------------------------------------
  logic              run_any, en_q, txd_q, txen_q, rxd_q, cd_q, arb_q;
  logic [LINK_W-1:0] lo_q, lo_d, loe_q, loe_d, lrx_q;
  assign run_any = (st_q == ST_RUN) || (st_q == ST_UNCONF);

  // Open-drain lines only ever pull low; spare stays released
  for (genvar b = 0; b < LINK_W; b++) begin : g_link
    always_comb begin
      if (SPARE_MASK[b]) begin
        lo_d[b] = 1'b0; loe_d[b] = 1'b0;
      end else if (OD_MASK[b]) begin
        lo_d[b] = 1'b0;
        loe_d[b] = run_any && link_tx_en_in[b] && !link_tx_in[b];
      end else begin
        lo_d[b] = link_tx_in[b];
        loe_d[b] = run_any && link_tx_en_in[b];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      en_q <= 1'b0; txd_q <= 1'b0; txen_q <= 1'b0; rxd_q <= 1'b0; cd_q <= 1'b0;
      lo_q <= '0; loe_q <= '0; lrx_q <= '0; arb_q <= 1'b0;
    end else begin
      en_q <= run_any;
      txd_q <= run_any && mac_txd_in;
      txen_q <= run_any && mac_tx_en_in;
      rxd_q <= flt_q[5];
      cd_q <= flt_q[6];
      lo_q <= lo_d; loe_q <= loe_d; lrx_q <= link_s;
      arb_q <= run_any;
    end
  end

  assign rst_line_n_out    = 1'b0;
  assign rst_line_oe_out   = oe_q;
  assign link_lines_out    = lo_q;
  assign link_lines_oe_out = loe_q;
  assign link_rx_out       = lrx_q;
  assign net_txd_out       = txd_q;
  assign net_tx_en_out     = txen_q;
  assign mac_rxd_out       = rxd_q;
  assign mac_cd_out        = cd_q;
  assign net_bit_div_out   = div_q;
  assign net_enable_out    = en_q;
  assign configured_out    = cfgd_q;
  assign arb_ok_out        = arb_q;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  chk_src_drives_line: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    src_any |=> oe_q [*1] ##1 (oe_q || !src_any))
    else $error("reset source did not drive line");
  chk_spare_idle: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !link_lines_oe_out[SPARE_BIT])
    else $error("spare line driven");
  chk_hs_low_only: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    link_lines_oe_out[HS_BIT] |-> !link_lines_out[HS_BIT])
    else $error("handshake driven high");
  chk_load_before_run: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (run_any && !$past(run_any)) |-> $past(st_q) == ST_LOAD)
    else $error("network enabled without load");
  chk_default_rate: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (st_q == ST_UNCONF) |-> div_q == 16'(DEF_DIV) && !cfgd_q)
    else $error("unconfigured without defaults");
  chk_ext_request: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (run_any && !line_hi && !src_any) |=> st_q == ST_HOLD ##1 !en_q)
    else $error("external reset ignored");
  chk_bounce_restart: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (st_q == ST_SETTLE && !line_hi && !src_any) |=> cnt_q == '0)
    else $error("bounce did not restart wait");
  chk_tx_gated: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !run_any |=> !net_tx_en_out && !net_enable_out)
    else $error("transmit outside run");
endmodule : hbr_reset_boot
`default_nettype wire

// *** verif/hbr_peer_model.sv ***
`default_nettype none
module hbr_peer_model
  import hbr_pkg::*;
#(
  parameter logic [15:0] IMG_DIV = 16'h0040
) (
  // Clock
  input  wire logic              clk_in,
  // Serial memory pins
  input  wire logic              sck_in,
  input  wire logic              cs_n_in,
  input  wire logic              mosi_in,
  output logic                   miso_out,
  output logic [23:0]            cmd_out,
  output logic [31:0]            rise_out,
  // Inter-half wires
  input  wire logic [LINK_W-1:0] link_out_in,
  input  wire logic [LINK_W-1:0] link_oe_in,
  input  wire logic [LINK_W-1:0] peer_en_in,
  input  wire logic [LINK_W-1:0] peer_val_in,
  output logic [LINK_W-1:0]      wire_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // --------------------
  // Serial memory
  // --------------------
  logic [7:0]        mem_q [CFG_BYTES];
  logic [7:0]        sum;
  logic [LINK_W-1:0] float_q = '0;
  int                idx;

  // Image is in place before attach; last byte trims the sum to zero
  initial begin
    sum = 8'h00;
    for (int i = 0; i < CFG_BYTES - 1; i++) begin
      mem_q[i] = (i == 0) ? IMG_DIV[15:8] : (i == 1) ? IMG_DIV[7:0] : i[7:0] ^ 8'h5A;
      sum = sum + mem_q[i];
    end
    mem_q[CFG_BYTES-1] = 8'h00 - sum;
    miso_out = 1'b0;
    cmd_out = 24'h000000;
    rise_out = 32'h0;
  end

  // Command capture on rising clock; select fall restarts the count
  always @(posedge sck_in or negedge cs_n_in) begin
    if (!sck_in) begin
      rise_out <= 32'h0;
    end else if (!cs_n_in) begin
      if (rise_out < CMD_BITS) cmd_out <= {cmd_out[22:0], mosi_in};
      rise_out <= rise_out + 32'h1;
    end
  end

  // Data shifted on falling clock; unselected output wanders, no pull
  always @(negedge sck_in or posedge cs_n_in) begin
    idx = int'(rise_out) - int'(CMD_BITS);
    if (cs_n_in || idx < 0 || idx >= int'(CFG_BYTES) * 8) begin
      miso_out <= ~miso_out;
    end else begin
      miso_out <= mem_q[idx/8][7-idx%8];
    end
  end

  // --------------------
  // Inter-half wires
  // --------------------
  // Undriven plain lines toggle so a stale level never looks valid
  always @(posedge clk_in) begin
    float_q <= ~float_q;
  end

  // Pulled-up lines are wired-AND; plain lines take whoever drives
  always_comb begin
    for (int b = 0; b < LINK_W; b++) begin
      if (OD_MASK[b] || SPARE_MASK[b]) begin
        wire_out[b] = !(link_oe_in[b] && !link_out_in[b])
                      && !(peer_en_in[b] && !peer_val_in[b]);
      end else if (link_oe_in[b]) begin
        wire_out[b] = link_out_in[b];
      end else if (peer_en_in[b]) begin
        wire_out[b] = peer_val_in[b];
      end else begin
        wire_out[b] = float_q[b];
      end
    end
  end
endmodule : hbr_peer_model
`default_nettype wire

// *** verif/testbench.sv ***
`default_nettype none
module testbench
  import hbr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int          DEB = 16;
  localparam logic [15:0] DIV = 16'h0040;

  logic        clk, rst_n, ext_low, txd, txen, rxd, cd, sck, csn, mosi, miso;
  logic        roe, rout, rst_wire, ntxd, ntxen, mrxd, mcd, nen, cfgd, arbok;
  logic [3:0]  src;
  logic [11:0] ltx, lten, pen, pval, lwire, lout, loe, lrx;
  logic [15:0] ndiv;
  logic [23:0] cmd;
  logic [31:0] rises;
  int          miscompares = 0;
  int          cmp_count = 0;

  // Outside parties only sink the reset line
  assign rst_wire = !(roe && !rout) && !ext_low;

  hbr_reset_boot #(.DEB_LEN(DEB)) i_dut (
    .core_clk_in(clk), .reset_n_in(rst_n), .rst_line_n_in(rst_wire),
    .rst_line_n_out(rout), .rst_line_oe_out(roe), .low_voltage_detector_in(src[0]),
    .sw_reset_in(src[1]), .watchdog_expired_in(src[2]), .trap_in(src[3]),
    .link_lines_in(lwire), .link_lines_out(lout), .link_lines_oe_out(loe),
    .link_tx_in(ltx), .link_tx_en_in(lten), .link_rx_out(lrx), .mem_sck_out(sck),
    .mem_cs_n_out(csn), .mem_mosi_out(mosi), .mem_miso_in(miso), .net_rxd_in(rxd),
    .net_cd_in(cd), .net_txd_out(ntxd), .net_tx_en_out(ntxen), .mac_txd_in(txd),
    .mac_tx_en_in(txen), .mac_rxd_out(mrxd), .mac_cd_out(mcd), .net_bit_div_out(ndiv),
    .net_enable_out(nen), .configured_out(cfgd), .arb_ok_out(arbok));

  hbr_peer_model #(.IMG_DIV(DIV)) i_peer (
    .clk_in(clk), .sck_in(sck), .cs_n_in(csn), .mosi_in(mosi), .miso_out(miso),
    .cmd_out(cmd), .rise_out(rises), .link_out_in(lout), .link_oe_in(loe),
    .peer_en_in(pen), .peer_val_in(pval), .wire_out(lwire));

  // --------------------
  // Shared tasks
  // --------------------
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check

  task automatic limit(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      $display("CHECK FAILED t=%0t wait got=%0h exp=%0h", $time, n, lim);
      close_out();
    end
  endtask : limit

  // --------------------
  // Scenarios
  // --------------------
  task automatic reset_vals();
    @(negedge clk);
    check(roe, 1'b0);
    check(loe, 12'h000);
    check(csn, 1'b1);
    check(ndiv, 32'(DEF_DIV));
  endtask : reset_vals

  // Core asks to transmit from the start; nothing may leave before run
  task automatic boot();
    int n;
    for (n = 0; n < 100000; n++) begin
      @(negedge clk);
      if (cfgd === 1'b1) break;
      if (nen !== 1'b0 || ntxen !== 1'b0) check({nen, ntxen}, 2'h0);
      if (loe[SPARE_BIT] !== 1'b0) check(loe[SPARE_BIT], 1'b0);
    end
    limit(n, 100000);
    // Enable and arbitration flags follow the state by one cycle
    @(negedge clk);
    check(nen, 1'b1);
    check(ndiv, DIV);
    check(cmd, SPI_READ_CMD);
    check(rises, XFER_BITS);
    check(arbok, 1'b1);
  endtask : boot

  task automatic net_path();
    int n;
    @(posedge clk);
    txd <= 1'b1;
    rxd <= 1'b1;
    cd <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check({ntxd, ntxen}, 2'h3);
    @(posedge clk);
    txd <= 1'b0;
    txen <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check({ntxd, ntxen}, 2'h0);
    for (n = 0; n < 10; n++) begin
      @(negedge clk);
      if (mrxd === 1'b1 && mcd === 1'b1) break;
    end
    limit(n, 10);
    check({mrxd, mcd}, 2'h3);
  endtask : net_path

  task automatic link_port();
    int n;
    @(posedge clk);
    lten <= 12'h408;
    ltx <= 12'h008;
    @(posedge clk);
    @(negedge clk);
    check({loe, lout & loe}, {12'h408, 12'h008});
    @(posedge clk);
    lten <= 12'hC08;
    ltx <= 12'hC08;
    @(posedge clk);
    @(negedge clk);
    check(loe, 12'h008);
    check(lwire[11:10], 2'h3);
    @(posedge clk);
    pen <= 12'h420;
    pval <= 12'h000;
    for (n = 0; n < 10; n++) begin
      @(negedge clk);
      if ((lrx & 12'h420) === 12'h000) break;
    end
    limit(n, 10);
    check(lrx & 12'h420, 12'h000);
    @(posedge clk);
    pen <= 12'h000;
    lten <= 12'h000;
  endtask : link_port

  // Bouncing button: highs shorter than the settle time restart it
  task automatic ext_reset();
    int n;
    @(posedge clk);
    ext_low <= 1'b1;
    for (n = 0; n < 12; n++) begin
      @(negedge clk);
      if (nen === 1'b0) break;
    end
    limit(n, 12);
    check({nen, roe}, 2'h0);
    repeat (4) begin
      @(posedge clk);
      ext_low <= 1'b0;
      repeat (DEB / 2) @(posedge clk);
      ext_low <= 1'b1;
      repeat (6) @(posedge clk);
      if (csn !== 1'b1) check(csn, 1'b1);
    end
    ext_low <= 1'b0;
    for (n = 0; n < DEB + ARB_CYCLES + 30; n++) begin
      @(negedge clk);
      if (csn === 1'b0) break;
    end
    limit(n, DEB + ARB_CYCLES + 30);
    check(n >= DEB + ARB_CYCLES, 1'b1);
  endtask : ext_reset

  task automatic int_sources();
    int n;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      src[i] <= 1'b1;
      for (n = 0; n < 10; n++) begin
        @(negedge clk);
        if (roe === 1'b1) break;
      end
      limit(n, 10);
      repeat (20) @(negedge clk);
      check({roe, rout, rst_wire, nen}, 4'h8);
      @(posedge clk);
      src[i] <= 1'b0;
      for (n = 0; n < HOLD_CYCLES + 20; n++) begin
        @(negedge clk);
        if (roe === 1'b0) break;
      end
      limit(n, HOLD_CYCLES + 20);
      check(n >= HOLD_CYCLES && n <= HOLD_CYCLES + 10, 1'b1);
      check(rst_wire, 1'b1);
    end
  endtask : int_sources

  // --------------------
  // Clock, watchdog, sequence
  // --------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Cuts a hung run short
  initial begin
    #440000;
    limit(1, 0);
  end

  initial begin
    rst_n = 1'b0;
    ext_low = 1'b0;
    src = 4'h0;
    ltx = 12'h000;
    lten = 12'h000;
    pen = 12'h000;
    pval = 12'h000;
    rxd = 1'b0;
    cd = 1'b0;
    txd = 1'b0;
    txen = 1'b1;
    repeat (12) @(posedge clk);
    reset_vals();
    @(posedge clk);
    rst_n <= 1'b1;
    boot();
    net_path();
    link_port();
    ext_reset();
    int_sources();
    close_out();
  end
endmodule : testbench
`default_nettype wire
